//--- verilog/usb_list_start_address_pkg.sv
// constants, register map and carrier types of the endpoint list / LINK_POWER_CONTROL block
// assumes one 250 MHz clock and a plain single-cycle register port
package usb_list_start_address_pkg;

   localparam int          NUM_EP       = 10;
   localparam int          NUM_SKIP     = 30;
   localparam logic [31:0] ADR_LIST     = 32'h4008_0008;
   localparam logic [31:0] ADR_BUFPAGE  = 32'h4008_000C;
   localparam logic [31:0] ADR_LPM      = 32'h4008_0010;
   localparam logic [31:0] ADR_SKIP     = 32'h4008_0014;
   localparam logic [31:0] ADR_INUSE    = 32'h4008_0018;
   localparam logic [31:0] ADR_BUFCFG   = 32'h4008_001C;
   localparam logic [31:0] ADR_INTSTAT  = 32'h4008_0020;
   localparam logic [31:0] ADR_INTMASK  = 32'h4008_0024;

   localparam int          LIST_LSB     = 8;
   localparam int          PAGE_LSB     = 22;
   localparam int          HOST_RESUME_LSB = 0;
   localparam int          DEV_RESUME_LSB  = 4;
   localparam int          PENDING_BIT  = 8;
   localparam int          EP_LSB       = 2;

   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   localparam logic [3:0]  RST_NIBBLE   = 4'h0;

   typedef struct packed {
      logic       valid;
      logic [3:0] hird;
   } lpm_token_s;

   typedef struct packed {
      logic valid;
      logic nyet;
   } handshake_s;

   typedef struct packed {
      logic       valid;
      logic [4:0] ep;
      logic       buf_sel;
   } deact_s;

endpackage : usb_list_start_address_pkg

//--- verilog/usb_list_start_address_ctrl.sv
// endpoint list base, buffer page, LINK_POWER_CONTROL handshake, skip and buffer select registers
// assumes the packet engine reports active clears and LINK_POWER_CONTROL tokens as one-cycle pulses
module usb_list_start_address_ctrl
   import usb_list_start_address_pkg::*;
(
   input  wire logic                CLOCK,
   input  wire logic                RST_N,
   input  wire logic [31:0]         ADDR,
   input  wire logic [31:0]         WDATA,
   input  wire logic                WR,
   input  wire logic                RD,
   output logic [31:0]              RDATA,
   input  wire logic                LPM_SUPPORTED,
   input  wire lpm_token_s          LPM_TOKEN,
   output handshake_s               LPM_HANDSHAKE,
   input  wire logic [NUM_EP-1:0]   ACTIVE_FALL,
   output deact_s                   DEACT,
   output logic [31:0]              LIST_BASE,
   output logic [31:0]              BUF_PAGE,
   output logic [NUM_EP-1:0]        BUF_SELECT,
   output logic [3:0]               DEV_RESUME,
   output logic                     IRQ
);

   logic                rst_meta_ff;
   logic                rst_sync_ff;
   logic [23:0]         list_ff;
   logic [9:0]          page_ff;
   logic [3:0]          host_resume_ff;
   logic [3:0]          dev_resume_ff;
   logic                pending_ff;
   logic [NUM_SKIP-1:0] skip_ff;
   logic [NUM_EP-1:0]   inuse_ff;
   logic [NUM_EP-1:0]   bufcfg_ff;
   logic [NUM_EP-1:0]   intstat_ff;
   logic [NUM_EP-1:0]   intmask_ff;
   logic [31:0]         rdata_ff;
   handshake_s          hs_ff;
   deact_s              deact_ff;
   logic                irq_ff;

   logic                skip_hit;
   logic [4:0]          skip_idx;
   logic [NUM_SKIP-1:0] skip_done;
   logic [NUM_EP-1:0]   skip_ev;
   logic [NUM_EP-1:0]   toggle;
   logic [31:0]         rd_word;

   function automatic logic wr_hit(input logic [31:0] a);
      return WR && (ADDR == a);
   endfunction : wr_hit

   // lowest pending skip first; one endpoint is released per cycle
   always_comb begin
      skip_hit  = 1'b0;
      skip_idx  = 5'h00;
      skip_done = '0;
      for (int i = NUM_SKIP - 1; i >= 0; i--) begin
         if (skip_ff[i]) begin
            skip_hit = 1'b1;
            skip_idx = 5'(i);
         end
      end
      if (skip_hit) begin
         skip_done[skip_idx] = 1'b1;
      end
      skip_ev = skip_done[NUM_EP-1:0];
   end

   // engine clears toggle double-buffered selects; skip releases never do
   always_comb begin
      toggle = ACTIVE_FALL & bufcfg_ff;
      toggle[1:0] = 2'b00;
   end

   always_comb begin
      rd_word = RST_WORD;
      unique case (ADDR)
         ADR_LIST:    rd_word = {list_ff, 8'h00};
         ADR_BUFPAGE: rd_word = {page_ff, 22'h000000};
         ADR_LPM:     rd_word = {23'h000000, pending_ff, dev_resume_ff, host_resume_ff};
         ADR_SKIP:    rd_word = {2'b00, skip_ff};
         ADR_INUSE:   rd_word = {22'h000000, inuse_ff};
         ADR_BUFCFG:  rd_word = {22'h000000, bufcfg_ff};
         ADR_INTSTAT: rd_word = {22'h000000, intstat_ff};
         ADR_INTMASK: rd_word = {22'h000000, intmask_ff};
         default:     rd_word = RST_WORD;
      endcase
   end

   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         list_ff <= '0;
         page_ff <= '0;
      end else begin
         if (wr_hit(ADR_LIST)) begin
            list_ff <= WDATA[31:LIST_LSB];
         end
         if (wr_hit(ADR_BUFPAGE)) begin
            page_ff <= WDATA[31:PAGE_LSB];
         end
      end
   end

   always_ff @(posedge CLOCK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         dev_resume_ff  <= RST_NIBBLE;
         pending_ff     <= 1'b0;
         host_resume_ff <= RST_NIBBLE;
      end else begin
         if (wr_hit(ADR_LPM)) begin
            dev_resume_ff <= WDATA[DEV_RESUME_LSB+3:DEV_RESUME_LSB];
            pending_ff    <= WDATA[PENDING_BIT];
         end
         if (LPM_TOKEN.valid) begin
            host_resume_ff <= LPM_TOKEN.hird;
         end
      end
   end

   // no handshake at all when LINK_POWER_CONTROL is unsupported; the engine answers then
   always_ff @(posedge CLOCK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         hs_ff <= '0;
      end else begin
         hs_ff.valid <= LPM_TOKEN.valid && LPM_SUPPORTED;
         hs_ff.nyet  <= pending_ff;
      end
   end

   // a software write in the same cycle as a release wins over the self-clear
   always_ff @(posedge CLOCK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         skip_ff  <= '0;
         deact_ff <= '0;
      end else begin
         if (wr_hit(ADR_SKIP)) begin
            skip_ff <= WDATA[NUM_SKIP-1:0];
         end else begin
            skip_ff <= skip_ff & ~skip_done;
         end
         deact_ff.valid   <= skip_hit;
         deact_ff.ep      <= skip_idx;
         deact_ff.buf_sel <= (skip_idx < 5'(NUM_EP)) ? inuse_ff[skip_idx[3:0]] : 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         inuse_ff  <= '0;
         bufcfg_ff <= '0;
      end else begin
         if (wr_hit(ADR_INUSE)) begin
            inuse_ff <= {WDATA[NUM_EP-1:EP_LSB], 2'b00};
         end else begin
            inuse_ff <= inuse_ff ^ toggle;
         end
         if (wr_hit(ADR_BUFCFG)) begin
            bufcfg_ff <= {WDATA[NUM_EP-1:EP_LSB], 2'b00};
         end
      end
   end

   // set wins over a write-one clear landing in the same cycle
   always_ff @(posedge CLOCK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         intstat_ff <= '0;
         intmask_ff <= '0;
         irq_ff     <= 1'b0;
      end else begin
         if (wr_hit(ADR_INTSTAT)) begin
            intstat_ff <= (intstat_ff & ~WDATA[NUM_EP-1:0])
                          | ACTIVE_FALL | skip_ev;
         end else begin
            intstat_ff <= intstat_ff | ACTIVE_FALL | skip_ev;
         end
         if (wr_hit(ADR_INTMASK)) begin
            intmask_ff <= WDATA[NUM_EP-1:0];
         end
         irq_ff <= |(intstat_ff & intmask_ff);
      end
   end

   always_ff @(posedge CLOCK or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         rdata_ff <= RST_WORD;
      end else begin
         rdata_ff <= RD ? rd_word : RST_WORD;
      end
   end

   assign RDATA         = rdata_ff;
   assign LPM_HANDSHAKE = hs_ff;
   assign DEACT         = deact_ff;
   assign LIST_BASE     = {list_ff, 8'h00};
   assign BUF_PAGE      = {page_ff, 22'h000000};
   assign BUF_SELECT    = inuse_ff;
   assign DEV_RESUME    = dev_resume_ff;
   assign IRQ           = irq_ff;

endmodule : usb_list_start_address_ctrl

//--- testbench/usb_host_model.sv
// usb host stand-in: sends lpm tokens and records the handshake seen
// assumes the block answers in the cycle after the token edge
module usb_host_model
   import usb_list_start_address_pkg::*;
(
   input  wire logic       clock,
   input  wire handshake_s hs,
   output lpm_token_s      token
);
   timeunit 1ns;
   timeprecision 1ps;
   handshake_s seen;
   initial token = '0;
   task automatic send(input logic [3:0] h);
      @(posedge clock) token <= '{1'b1, h};
      // released duration shows the inverse so a stale capture is seen
      @(posedge clock) token <= '{1'b0, ~h};
      @(negedge clock) seen = hs;
   endtask : send
endmodule : usb_host_model

//--- testbench/usb_list_start_address_ctrl_chk.sv
// port checks for the endpoint list / lpm block
// assumes the bench keeps software writes apart from skip releases
module usb_list_start_address_ctrl_chk
   import usb_list_start_address_pkg::*;
(
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic [31:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        LPM_SUPPORTED,
   input wire lpm_token_s  LPM_TOKEN,
   input wire handshake_s  LPM_HANDSHAKE,
   input wire deact_s      DEACT,
   input wire logic [31:0] LIST_BASE,
   input wire logic [31:0] BUF_PAGE,
   input wire logic [9:0]  BUF_SELECT,
   input wire logic [3:0]  DEV_RESUME
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   // mirror of the pending bit, so the nyet answer can be judged from the port
   logic pending_q;
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pending_q <= 1'b0;
      end else if (WR && ADDR == ADR_LPM) begin
         pending_q <= WDATA[PENDING_BIT];
      end
   end
   a_list_write: assert property (WR && ADDR == ADR_LIST |=>
      LIST_BASE == {$past(WDATA[31:8]), 8'h00}) else $error("list base wrong");
   a_page_write: assert property (WR && ADDR == ADR_BUFPAGE |=>
      BUF_PAGE == {$past(WDATA[31:22]), 22'h0}) else $error("buffer page wrong");
   a_resume_write: assert property (WR && ADDR == ADR_LPM |=>
      DEV_RESUME == $past(WDATA[7:4])) else $error("resume field wrong");
   a_lpm_answer: assert property (LPM_TOKEN.valid && LPM_SUPPORTED |=>
      LPM_HANDSHAKE.valid) else $error("no lpm handshake");
   a_lpm_refuse: assert property (LPM_HANDSHAKE.valid |->
      $past(LPM_TOKEN.valid && LPM_SUPPORTED)) else $error("unasked handshake");
   a_lpm_nyet_kind: assert property (LPM_HANDSHAKE.valid |->
      LPM_HANDSHAKE.nyet == $past(pending_q)) else $error("lpm handshake kind wrong");
   a_skip_start: assert property (WR && ADDR == ADR_SKIP && WDATA[29:0] != 30'h0 |=>
      ##1 DEACT.valid) else $error("skip not released");
   a_skip_select: assert property (DEACT.valid |->
      DEACT.buf_sel == (DEACT.ep < 10 && BUF_SELECT[DEACT.ep])) else $error("deact select");
   a_ep0_single: assert property (BUF_SELECT[1:0] == 2'h0)
      else $error("select bits 1:0 set");
   cover property (DEACT.valid && DEACT.ep >= 10);
   cover property (LPM_HANDSHAKE.valid && LPM_HANDSHAKE.nyet);
   cover property (LPM_HANDSHAKE.valid && !LPM_HANDSHAKE.nyet);
endmodule : usb_list_start_address_ctrl_chk

bind usb_list_start_address_ctrl usb_list_start_address_ctrl_chk u_chk (.*);

//--- testbench/usb_list_start_address_ctrl_bench.sv
// self-checking bench for the endpoint list / lpm block
// assumes the host model drives the lpm token port
module usb_list_start_address_ctrl_bench
   import usb_list_start_address_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLOCK = 0, RST_N = 0, WR = 0, RD = 0, LPM_SUPPORTED = 0, IRQ;
   logic [31:0] ADDR = '0, WDATA = '0, RDATA, LIST_BASE, BUF_PAGE, d, s, m;
   logic [9:0] ACTIVE_FALL = '0, BUF_SELECT;
   logic [3:0] DEV_RESUME, h;
   logic [29:0] left;
   logic [4:0] ep;
   lpm_token_s LPM_TOKEN;
   handshake_s LPM_HANDSHAKE;
   deact_s DEACT;
   int failures = 0, comparisons = 0;
   logic [31:0] adr [6] = '{ADR_LIST, ADR_BUFPAGE, ADR_LPM, ADR_INUSE, ADR_BUFCFG, ADR_INTMASK};
   logic [31:0] msk [6] = '{32'hFFFFFF00, 32'hFFC00000, 32'h1F0, 32'h3FC, 32'h3FC, 32'h3FF};
   usb_list_start_address_ctrl u_dut (.*);
   usb_host_model u_host (.clock(CLOCK), .hs(LPM_HANDSHAKE), .token(LPM_TOKEN));
   always #2 CLOCK = ~CLOCK;
   task automatic chk(input string n, input logic [31:0] v, e);
      comparisons++;
      if (v !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, v);
      end
   endtask : chk
   function automatic logic [4:0] lowest(input logic [29:0] v);
      lowest = 5'h00;
      for (int i = 29; i >= 0; i--) if (v[i]) lowest = 5'(i);
   endfunction : lowest
   task automatic wr(input logic [31:0] a, v);
      @(posedge CLOCK) {ADDR, WDATA, WR} <= {a, v, 1'b1};
      @(posedge CLOCK) WR <= 0;
   endtask : wr
   task automatic rd(input logic [31:0] a, e);
      @(posedge CLOCK) {ADDR, RD} <= {a, 1'b1};
      @(posedge CLOCK) RD <= 0;
      @(negedge CLOCK) chk("rdata", RDATA, e);
   endtask : rd
   task automatic results;
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge CLOCK);
      failures++;
      results();
   end
   initial begin
      d = $urandom(72101);
      repeat (20) @(posedge CLOCK);
      RST_N <= 1;
      repeat (4) @(posedge CLOCK);
      // last address is past the map and must read zero
      for (int i = 0; i < 9; i++) rd(ADR_LIST + 4 * i, '0);
      for (int r = 0; r < 4; r++)
         foreach (adr[i]) begin
            d = r ? $urandom : '1;
            wr(adr[i], d);
            rd(adr[i], d & msk[i]);
            if (i == 0) chk("list base", LIST_BASE, d & msk[0]);
            if (i == 1) chk("buffer page", BUF_PAGE, d & msk[1]);
            if (i == 2) chk("resume", DEV_RESUME, d[7:4]);
         end
      s = $urandom & 32'h3FC;
      d = $urandom & 32'h3FFFFFFF | 32'h205;
      wr(ADR_INUSE, s);
      wr(ADR_INTMASK, 32'h3FF);
      wr(ADR_SKIP, d);
      left = d[29:0];
      // releases come one a cycle, lowest bit first
      for (int c = 0; c < 32; c++) begin
         @(negedge CLOCK);
         if (DEACT.valid) begin
            ep = lowest(left);
            chk("deact", DEACT, {1'b1, ep, ep < 5'h0A && s[ep]});
            left[ep] = 1'b0;
         end
      end
      chk("skip left", left, '0);
      rd(ADR_SKIP, '0);
      chk("select", BUF_SELECT, s);
      wr(ADR_INTSTAT, '0);
      rd(ADR_INTSTAT, d & 32'h3FF);
      chk("irq", IRQ, 32'h1);
      wr(ADR_INTSTAT, '1);
      rd(ADR_INTSTAT, '0);
      chk("irq", IRQ, '0);
      m = $urandom & 32'h3FC;
      d = $urandom & 32'h3FF;
      wr(ADR_BUFCFG, m);
      @(posedge CLOCK) ACTIVE_FALL <= d[9:0];
      @(posedge CLOCK) ACTIVE_FALL <= '0;
      rd(ADR_INUSE, s ^ (d & m));
      rd(ADR_INTSTAT, d);
      wr(ADR_INTMASK, '0);
      rd(ADR_INTMASK, '0);
      chk("irq", IRQ, '0);
      for (int k = 0; k < 4; k++) begin
         h = 4'($urandom);
         @(posedge CLOCK) LPM_SUPPORTED <= k[1];
         wr(ADR_LPM, {23'h0, k[0], 8'h00});
         u_host.send(h);
         chk("handshake", u_host.seen & {1'b1, k[1]}, {k[1], k[1] & k[0]});
         rd(ADR_LPM, {23'h0, k[0], 4'h0, h});
      end
      results();
   end
endmodule : usb_list_start_address_ctrl_bench
